// >>> core/rx_ring_pkg.sv
// constants, field layouts and carrier types for the receive ring write-back engine
package rx_ring_pkg;

	// register bus geometry
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] REG_CTRL_OFF   = 8'h00;
	localparam logic [7:0] REG_BASE_OFF   = 8'h04;
	localparam logic [7:0] REG_LEN_OFF    = 8'h08;
	localparam logic [7:0] REG_STATUS_OFF = 8'h0c;

	// control register fields and reset values
	localparam int          CTRL_ENABLE_BIT    = 0;
	localparam int          CTRL_CHAIN_DIS_BIT = 1;
	localparam logic [1:0]  CTRL_RESET         = 2'h0;
	localparam logic [17:0] BASE_RESET         = 18'h00000;
	localparam logic [7:0]  LEN_RESET          = 8'h01;

	// status register fields
	localparam int STAT_IN_FRAME_BIT = 8;
	localparam int STAT_ENABLED_BIT  = 9;
	localparam int STAT_FRAMES_LSB   = 16;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// memory side geometry
	localparam int MEM_ADDR_W = 18;
	localparam int MEM_DATA_W = 16;
	localparam int IDX_W      = 8;
	localparam int MESSAGE_LENGTH_W     = 12;

	// descriptor entry layout: four 16-bit words, eight bytes apart
	localparam logic [17:0] DESC_LEN_OFF    = 18'h00000;
	localparam logic [17:0] DESC_ADDR_OFF   = 18'h00002;
	localparam logic [17:0] DESC_STATUS_OFF = 18'h00004;
	localparam logic [17:0] DESC_MESSAGE_LENGTH_OFF   = 18'h00006;
	localparam int          DESC_SHIFT      = 3;

	// third word fields
	localparam int OWN_BIT       = 15;
	localparam int ERRSUM_BIT    = 14;
	localparam int FRAMING_ERROR_BIT      = 13;
	localparam int FRAME_OVERFLOW_BIT      = 12;
	localparam int CRC_BIT       = 11;
	localparam int START_BIT     = 9;
	localparam int END_BIT       = 8;
	localparam int ADDR_HI_LSB   = 0;

	// fourth word fields
	localparam int BUFFER_LENGTH_ERROR_BIT = 15;
	localparam int BUS_TIMEOUT_ERROR_BIT = 14;
	localparam int NO_CHAINING_FLAG_BIT = 13;
	localparam int OVERRUN_ERROR_BIT = 12;

	// frame size limits
	localparam logic [11:0] MAX_DATA_BYTES   = 12'd1500;
	localparam logic [11:0] HEADER_BYTES     = 12'd14;
	localparam logic [11:0] MAX_FRAME_BYTES  = MAX_DATA_BYTES + HEADER_BYTES;
	localparam logic [11:0] MESSAGE_LENGTH_SATURATE    = 12'hfff;

	// sticky per-entry flag positions
	localparam int FLAG_N    = 7;
	localparam int FLG_FRAMING_ERROR  = 0;
	localparam int FLG_FRAME_OVERFLOW  = 1;
	localparam int FLG_CRC   = 2;
	localparam int FLG_BUFFER_LENGTH_ERROR  = 3;
	localparam int FLG_BUS_TIMEOUT_ERROR  = 4;
	localparam int FLG_NO_CHAINING_FLAG  = 5;
	localparam int FLG_OVERRUN_ERROR  = 6;

	// one memory request
	typedef struct packed {
		logic        we;
		logic [17:0] addr;
		logic [15:0] wdata;
	} mem_cmd_s;

endpackage

// >>> core/sticky_flags.sv
// bank of sticky flags where a set in the clearing cycle wins
`timescale 1ns/1ns
module sticky_flags #(
	parameter int N = 1
) (
	input  wire logic         clock_i,
	input  wire logic         nrst_i,
	input  wire logic [N-1:0] set_i,
	input  wire logic         clear_i,
	output logic      [N-1:0] flags_o
);

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : gen_flag
			// set is checked before clear so a coincident event survives
			always_ff @(posedge clock_i)
			begin
				if (!nrst_i)
					flags_o[g] <= 1'b0;
				else if (set_i[g])
					flags_o[g] <= 1'b1;
				else if (clear_i)
					flags_o[g] <= 1'b0;
			end
		end
	endgenerate

endmodule

// >>> core/rx_ring_writeback.sv
// receive ring engine: fills host buffers and writes back entry status
`timescale 1ns/1ns
module rx_ring_writeback (
	input  wire logic                   clock_i,
	input  wire logic                   nrst_i,
	input  wire logic [7:0]             s_axi_awaddr_i,
	input  wire logic                   s_axi_awvalid_i,
	output logic                        s_axi_awready_o,
	input  wire logic [31:0]            s_axi_wdata_i,
	input  wire logic [3:0]             s_axi_wstrb_i,
	input  wire logic                   s_axi_wvalid_i,
	output logic                        s_axi_wready_o,
	output logic [1:0]                  s_axi_bresp_o,
	output logic                        s_axi_bvalid_o,
	input  wire logic                   s_axi_bready_i,
	input  wire logic [7:0]             s_axi_araddr_i,
	input  wire logic                   s_axi_arvalid_i,
	output logic                        s_axi_arready_o,
	output logic [31:0]                 s_axi_rdata_o,
	output logic [1:0]                  s_axi_rresp_o,
	output logic                        s_axi_rvalid_o,
	input  wire logic                   s_axi_rready_i,
	input  wire logic                   rx_valid_i,
	input  wire logic [7:0]             rx_byte_i,
	input  wire logic                   rx_last_i,
	input  wire logic                   rx_crc_bad_i,
	input  wire logic                   rx_bits_odd_i,
	input  wire logic                   tx_fetch_i,
	input  wire logic [17:0]            tx_addr_i,
	output logic [7:0]                  tx_byte_o,
	output logic                        tx_byte_valid_o,
	output logic                        mem_req_o,
	output rx_ring_pkg::mem_cmd_s       mem_cmd_o,
	input  wire logic [15:0]            mem_rdata_i,
	input  wire logic                   mem_ack_i,
	input  wire logic                   mem_err_i
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_POLL, ST_W0, ST_W1, ST_RECV, ST_WRITE,
		ST_DRAIN, ST_NEXT, ST_WB3, ST_WB2, ST_TX
	} state_e;

	state_e                state;
	logic [1:0]            ctrl;
	logic [17:0]           rx_ring_base;
	logic [7:0]            ring_len;
	logic [7:0]            idx;
	logic [15:0]           frames;
	logic [17:0]           buffer_address;
	logic [15:0]           buffer_length;
	logic [15:0]           off;
	logic [7:0]            lo_byte;
	logic [7:0]            held_byte;
	logic                  half;
	logic                  chain;
	logic [1:0]            next_hi;
	logic                  start_marker;
	logic                  end_marker;
	logic                  tx_pend;
	logic [17:0]           tx_addr;
	logic                  in_frame;
	logic                  skip;
	logic                  last_seen;
	logic [11:0]           message_length;
	logic                  aw_have;
	logic                  w_have;
	logic [7:0]            aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic [31:0]           rd_mux;
	logic                  rd_hit;
	logic [rx_ring_pkg::FLAG_N-1:0] flags;
	logic [rx_ring_pkg::FLAG_N-1:0] flag_set;
	logic [rx_ring_pkg::FLAG_N-1:0] cur;
	logic                  accept;
	logic                  over_len;
	logic                  stop_chain;
	logic                  entry_done;
	logic                  frame_close;
	logic                  lost_byte;
	logic [17:0]           entry_addr;
	logic [7:0]            next_idx;
	logic [17:0]           data_addr;
	logic                  enable;
	logic                  rx_chain_disable;

	// control decode and ring addressing
	assign enable           = ctrl[rx_ring_pkg::CTRL_ENABLE_BIT];
	assign rx_chain_disable = ctrl[rx_ring_pkg::CTRL_CHAIN_DIS_BIT];
	assign entry_addr       = rx_ring_base + {7'h00, idx, 3'h0};
	assign next_idx = (idx + 8'h01 >= ring_len) ? 8'h00 : idx + 8'h01;
	assign data_addr = buffer_address + {2'h0, off[15:1], 1'b0};

	// frame-level conditions
	assign accept     = rx_valid_i && (state == ST_RECV) && !last_seen && !skip;
	assign over_len   = message_length > rx_ring_pkg::MAX_FRAME_BYTES;
	assign stop_chain = rx_chain_disable || over_len;
	assign entry_done = (state == ST_WB2) && mem_ack_i;
	assign frame_close = entry_done && end_marker;
	// bytes of an open frame that arrive while the engine is busy are dropped
	assign lost_byte = rx_valid_i && in_frame && !last_seen && (state != ST_RECV)
		&& (state != ST_DRAIN);

	// flag events of the current entry
	always_comb
	begin
		flag_set = '0;
		flag_set[rx_ring_pkg::FLG_FRAMING_ERROR] = rx_valid_i && rx_last_i && rx_bits_odd_i
			&& (in_frame || accept);
		flag_set[rx_ring_pkg::FLG_FRAME_OVERFLOW] = in_frame && over_len;
		flag_set[rx_ring_pkg::FLG_CRC]  = rx_valid_i && rx_last_i && rx_crc_bad_i
			&& (in_frame || accept);
		flag_set[rx_ring_pkg::FLG_BUFFER_LENGTH_ERROR] = (state == ST_NEXT) && mem_ack_i
			&& !mem_rdata_i[rx_ring_pkg::OWN_BIT];
		flag_set[rx_ring_pkg::FLG_BUS_TIMEOUT_ERROR] = (state == ST_WRITE) && mem_ack_i
			&& mem_err_i;
		flag_set[rx_ring_pkg::FLG_NO_CHAINING_FLAG] = (in_frame || accept) && rx_chain_disable;
		flag_set[rx_ring_pkg::FLG_OVERRUN_ERROR] = lost_byte;
	end

	// include this cycle's events so a write-back never misses them
	assign cur = flags | flag_set;

	sticky_flags #(
		.N (rx_ring_pkg::FLAG_N)
	) u_flags (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.set_i   (flag_set),
		.clear_i (entry_done),
		.flags_o (flags)
	);

	// frame tracking: length count, end capture, missed frame skipping
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			in_frame       <= 1'b0;
			skip           <= 1'b0;
			last_seen      <= 1'b0;
			message_length <= '0;
		end
		else if (frame_close)
		begin
			in_frame       <= 1'b0;
			last_seen      <= 1'b0;
			message_length <= '0;
			if (rx_valid_i)
				skip <= !rx_last_i;
		end
		else if (rx_valid_i)
		begin
			if ((in_frame && !last_seen) || accept)
			begin
				in_frame <= 1'b1;
				if (message_length != rx_ring_pkg::MESSAGE_LENGTH_SATURATE)
					message_length <= message_length + 12'h001;
				if (rx_last_i)
					last_seen <= 1'b1;
			end
			else if (!in_frame)
				skip <= !rx_last_i;
		end
	end

	// build one memory command
	function automatic rx_ring_pkg::mem_cmd_s cmd(input logic we, input logic [17:0] a,
		input logic [15:0] d);
		rx_ring_pkg::mem_cmd_s c;
		c.we    = we;
		c.addr  = a;
		c.wdata = d;
		return c;
	endfunction

	// entry walk, data moves and write-back; one memory request at a time
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			state           <= ST_IDLE;
			mem_req_o       <= 1'b0;
			mem_cmd_o       <= '0;
			idx             <= '0;
			frames          <= '0;
			buffer_address  <= '0;
			buffer_length   <= '0;
			off             <= '0;
			lo_byte         <= '0;
			held_byte       <= '0;
			half            <= 1'b0;
			chain           <= 1'b0;
			next_hi         <= '0;
			start_marker    <= 1'b0;
			end_marker      <= 1'b0;
			tx_pend         <= 1'b0;
			tx_addr         <= '0;
			tx_byte_o       <= '0;
			tx_byte_valid_o <= 1'b0;
		end
		else
		begin
			tx_byte_valid_o <= 1'b0;
			if (mem_ack_i)
				mem_req_o <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (tx_pend)
					begin
						mem_req_o <= 1'b1;
						mem_cmd_o <= cmd(1'b0, {tx_addr[17:1], 1'b0}, 16'h0000);
						state     <= ST_TX;
					end
					else if (enable)
					begin
						mem_req_o <= 1'b1;
						mem_cmd_o <= cmd(1'b0, entry_addr + rx_ring_pkg::DESC_STATUS_OFF,
							16'h0000);
						state     <= ST_POLL;
					end
				end
				ST_POLL:
					if (mem_ack_i)
					begin
						if (mem_rdata_i[rx_ring_pkg::OWN_BIT])
						begin
							buffer_address[17:16] <= mem_rdata_i[1:0];
							mem_req_o <= 1'b1;
							mem_cmd_o <= cmd(1'b0, entry_addr + rx_ring_pkg::DESC_LEN_OFF,
								16'h0000);
							state     <= ST_W0;
						end
						else
							state <= ST_IDLE;
					end
				ST_TX:
					if (mem_ack_i)
					begin
						// odd address takes the upper lane of the aligned word
						tx_byte_o       <= tx_addr[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
						tx_byte_valid_o <= 1'b1;
						state           <= ST_IDLE;
					end
				ST_W0:
					if (mem_ack_i)
					begin
						buffer_length <= {mem_rdata_i[15:1], 1'b0};
						mem_req_o     <= 1'b1;
						mem_cmd_o     <= cmd(1'b0, entry_addr + rx_ring_pkg::DESC_ADDR_OFF,
							16'h0000);
						state         <= ST_W1;
					end
				ST_W1:
					if (mem_ack_i)
					begin
						buffer_address[15:0] <= {mem_rdata_i[15:1], 1'b0};
						if (chain)
						begin
							// the byte that overflowed the last buffer opens this one
							lo_byte <= held_byte;
							half    <= 1'b1;
							off     <= 16'h0001;
							chain   <= 1'b0;
						end
						else
						begin
							half <= 1'b0;
							off  <= 16'h0000;
						end
						state <= ST_RECV;
					end
				ST_RECV:
				begin
					if (last_seen && half)
					begin
						mem_req_o <= 1'b1;
						mem_cmd_o <= cmd(1'b1, data_addr, {8'h00, lo_byte});
						half      <= 1'b0;
						state     <= ST_WRITE;
					end
					else if (last_seen)
					begin
						end_marker <= 1'b1;
						mem_req_o  <= 1'b1;
						mem_cmd_o  <= cmd(1'b1, entry_addr + rx_ring_pkg::DESC_MESSAGE_LENGTH_OFF,
							{cur[rx_ring_pkg::FLG_BUFFER_LENGTH_ERROR], cur[rx_ring_pkg::FLG_BUS_TIMEOUT_ERROR],
							cur[rx_ring_pkg::FLG_NO_CHAINING_FLAG], cur[rx_ring_pkg::FLG_OVERRUN_ERROR],
							message_length});
						state      <= ST_WB3;
					end
					else if (accept)
					begin
						if (!in_frame)
							start_marker <= 1'b1;
						if (off == buffer_length)
						begin
							if (stop_chain)
								state <= ST_DRAIN;
							else
							begin
								held_byte <= rx_byte_i;
								mem_req_o <= 1'b1;
								mem_cmd_o <= cmd(1'b0, rx_ring_base + {7'h00, next_idx, 3'h0}
									+ rx_ring_pkg::DESC_STATUS_OFF, 16'h0000);
								state     <= ST_NEXT;
							end
						end
						else if (half)
						begin
							mem_req_o <= 1'b1;
							mem_cmd_o <= cmd(1'b1, data_addr, {rx_byte_i, lo_byte});
							half      <= 1'b0;
							off       <= off + 16'h0001;
							state     <= ST_WRITE;
						end
						else
						begin
							lo_byte <= rx_byte_i;
							half    <= 1'b1;
							off     <= off + 16'h0001;
						end
					end
				end
				ST_WRITE:
					if (mem_ack_i)
						state <= ST_RECV;
				ST_DRAIN:
					if (last_seen)
					begin
						end_marker <= 1'b1;
						mem_req_o  <= 1'b1;
						mem_cmd_o  <= cmd(1'b1, entry_addr + rx_ring_pkg::DESC_MESSAGE_LENGTH_OFF,
							{cur[rx_ring_pkg::FLG_BUFFER_LENGTH_ERROR], cur[rx_ring_pkg::FLG_BUS_TIMEOUT_ERROR],
							cur[rx_ring_pkg::FLG_NO_CHAINING_FLAG], cur[rx_ring_pkg::FLG_OVERRUN_ERROR],
							message_length});
						state      <= ST_WB3;
					end
				ST_NEXT:
					if (mem_ack_i)
					begin
						if (mem_rdata_i[rx_ring_pkg::OWN_BIT])
						begin
							chain     <= 1'b1;
							next_hi   <= mem_rdata_i[1:0];
							mem_req_o <= 1'b1;
							mem_cmd_o <= cmd(1'b1, entry_addr + rx_ring_pkg::DESC_MESSAGE_LENGTH_OFF,
								{cur[rx_ring_pkg::FLG_BUFFER_LENGTH_ERROR], cur[rx_ring_pkg::FLG_BUS_TIMEOUT_ERROR],
								cur[rx_ring_pkg::FLG_NO_CHAINING_FLAG], cur[rx_ring_pkg::FLG_OVERRUN_ERROR],
								message_length});
							state     <= ST_WB3;
						end
						else
							state <= ST_DRAIN;
					end
				ST_WB3:
					if (mem_ack_i)
					begin
						// ownership goes back only in this last write
						mem_req_o <= 1'b1;
						mem_cmd_o <= cmd(1'b1, entry_addr + rx_ring_pkg::DESC_STATUS_OFF,
							{1'b0, cur[rx_ring_pkg::FLG_FRAMING_ERROR] | cur[rx_ring_pkg::FLG_CRC]
							| cur[rx_ring_pkg::FLG_BUFFER_LENGTH_ERROR] | cur[rx_ring_pkg::FLG_BUS_TIMEOUT_ERROR]
							| cur[rx_ring_pkg::FLG_OVERRUN_ERROR], cur[rx_ring_pkg::FLG_FRAMING_ERROR],
							cur[rx_ring_pkg::FLG_FRAME_OVERFLOW], cur[rx_ring_pkg::FLG_CRC], 1'b0,
							start_marker, end_marker, 6'h00,
							buffer_address[17:16]});
						state     <= ST_WB2;
					end
				ST_WB2:
					if (mem_ack_i)
					begin
						idx          <= next_idx;
						start_marker <= 1'b0;
						end_marker   <= 1'b0;
						if (end_marker)
						begin
							frames <= frames + 16'h0001;
							state  <= ST_IDLE;
						end
						else
						begin
							buffer_address[17:16] <= next_hi;
							mem_req_o <= 1'b1;
							mem_cmd_o <= cmd(1'b0, rx_ring_base + {7'h00, next_idx, 3'h0}
								+ rx_ring_pkg::DESC_LEN_OFF, 16'h0000);
							state     <= ST_W0;
						end
					end
				default:
					state <= ST_IDLE;
			endcase
			// a new fetch request wins over completion of the old one
			if (state == ST_TX && mem_ack_i)
				tx_pend <= 1'b0;
			if (tx_fetch_i)
			begin
				tx_pend <= 1'b1;
				tx_addr <= tx_addr_i;
			end
		end
	end

	// register read decode
	always_comb
	begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			rx_ring_pkg::REG_CTRL_OFF:   rd_mux = {30'h0, ctrl};
			rx_ring_pkg::REG_BASE_OFF:   rd_mux = {14'h0, rx_ring_base};
			rx_ring_pkg::REG_LEN_OFF:    rd_mux = {24'h0, ring_len};
			rx_ring_pkg::REG_STATUS_OFF: rd_mux = {frames, 6'h0, enable, in_frame, idx};
			default:                     rd_hit = 1'b0;
		endcase
	end

	// merge written bytes into a 32-bit register image
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[8*b +: 8] = d[8*b +: 8];
		return r;
	endfunction

	// write channels: address and data taken in either order, answer after both
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= rx_ring_pkg::RESP_OKAY;
			aw_have         <= 1'b0;
			w_have          <= 1'b0;
			aw_addr         <= '0;
			w_data          <= '0;
			w_strb          <= '0;
			ctrl            <= rx_ring_pkg::CTRL_RESET;
			rx_ring_base    <= rx_ring_pkg::BASE_RESET;
			ring_len        <= rx_ring_pkg::LEN_RESET;
		end
		else
		begin
			s_axi_awready_o <= !aw_have && !s_axi_bvalid_o && !(s_axi_awvalid_i && s_axi_awready_o);
			s_axi_wready_o  <= !w_have && !s_axi_bvalid_o && !(s_axi_wvalid_i && s_axi_wready_o);
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
			if (aw_have && w_have && !s_axi_bvalid_o)
			begin
				aw_have        <= 1'b0;
				w_have         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= rx_ring_pkg::RESP_OKAY;
				case (aw_addr)
					rx_ring_pkg::REG_CTRL_OFF:
						ctrl <= 2'(merge({30'h0, ctrl}, w_data, w_strb));
					rx_ring_pkg::REG_BASE_OFF:
						rx_ring_base <= 18'(merge({14'h0, rx_ring_base}, w_data, w_strb));
					rx_ring_pkg::REG_LEN_OFF:
						ring_len <= 8'(merge({24'h0, ring_len}, w_data, w_strb));
					rx_ring_pkg::REG_STATUS_OFF:
						s_axi_bresp_o <= rx_ring_pkg::RESP_OKAY;
					default:
						s_axi_bresp_o <= rx_ring_pkg::RESP_DECERR;
				endcase
			end
		end
	end

	// read channel: one read at a time, data registered with the answer
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= rx_ring_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= rd_mux;
				s_axi_rresp_o  <= rd_hit ? rx_ring_pkg::RESP_OKAY : rx_ring_pkg::RESP_DECERR;
			end
			else if (s_axi_rvalid_o && s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule

// >>> tb/rx_ring_monitor.sv
// port-level checks of the ring engine
`timescale 1ns/1ns
module rx_ring_monitor #(
	parameter logic [17:0] DESC_TOP = 18'h10
) (
	input wire logic                  clock_i,
	input wire logic                  nrst_i,
	input wire logic                  s_axi_awvalid_i,
	input wire logic                  s_axi_awready_o,
	input wire logic                  s_axi_wvalid_i,
	input wire logic                  s_axi_wready_o,
	input wire logic                  s_axi_bvalid_o,
	input wire logic                  s_axi_arvalid_i,
	input wire logic                  s_axi_arready_o,
	input wire logic                  s_axi_rvalid_o,
	input wire logic                  s_axi_rready_i,
	input wire logic                  tx_fetch_i,
	input wire logic                  tx_byte_valid_o,
	input wire logic                  mem_req_o,
	input wire rx_ring_pkg::mem_cmd_s mem_cmd_o,
	input wire logic                  mem_ack_i
);
	wire         d_wr = mem_req_o && mem_cmd_o.we && mem_cmd_o.addr < DESC_TOP;
	wire         st_wr = d_wr && mem_cmd_o.addr[2:0] == 3'h4;
	wire         ex_wr = d_wr && mem_cmd_o.addr[2:0] == 3'h6;
	wire  [15:0] wd = mem_cmd_o.wdata;
	logic [15:0] ext_q;
	logic        ext_ok;
	// the extended word must land just before the release write
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			ext_ok <= 1'b0;
		else if (d_wr && mem_ack_i)
			ext_ok <= ex_wr;
	end
	// its flags feed the summary check
	always_ff @(posedge clock_i)
	begin
		if (ex_wr && mem_ack_i)
			ext_q <= wd;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	a_own_last: assert property (st_wr |-> ext_ok && !wd[15])
		else $error("ownership not released last");
	a_error_summary_sum: assert property (st_wr |-> wd[14] ==
		(wd[13] | wd[11] | ext_q[15] | ext_q[14] | ext_q[12])) else $error("bad summary");
	a_zero_fields: assert property (st_wr |-> wd[10] == 1'b0 && wd[7:2] == 6'h0)
		else $error("reserved bits set");
	a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_cmd_o))
		else $error("memory request dropped");
	a_tx_answer: assert property (tx_fetch_i |-> ##[1:200] tx_byte_valid_o)
		else $error("byte fetch lost");
	a_tx_pulse: assert property (tx_byte_valid_o |=> !tx_byte_valid_o)
		else $error("fetch pulse too long");
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
		else $error("read answer dropped");
	c_chain: cover property (st_wr && wd[9] && !wd[8]);
	c_trunc: cover property (st_wr && ext_q[15]);
	c_fetch: cover property (tx_byte_valid_o);
endmodule
bind rx_ring_writeback rx_ring_monitor MON (.clock_i, .nrst_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i,
	.s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .tx_fetch_i, .tx_byte_valid_o,
	.mem_req_o, .mem_cmd_o, .mem_ack_i);

// >>> tb/host_mem_model.sv
// host memory answering engine word requests after a short or long wait
`timescale 1ns/1ns
module host_mem_model (
	input  wire logic                  clock_i,
	input  wire logic                  slow_i,
	input  wire logic                  req_i,
	input  wire rx_ring_pkg::mem_cmd_s cmd_i,
	output logic [15:0]                rdata_o,
	output logic                       ack_o
);
	logic [15:0] mem [0:2047];
	logic [2:0]  wait_q = 3'h0;
	initial
	begin
		rdata_o = 16'h0;
		ack_o = 1'b0;
	end
	// idle data lines toggle so a stale word never passes for an answer
	always @(posedge clock_i)
	begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o && wait_q >= (slow_i ? 3'h4 : 3'h0))
		begin
			ack_o <= 1'b1;
			wait_q <= 3'h0;
			if (cmd_i.we)
				mem[cmd_i.addr[11:1]] <= cmd_i.wdata;
			else
				rdata_o <= mem[cmd_i.addr[11:1]];
		end
		else if (req_i && !ack_o)
			wait_q <= wait_q + 3'h1;
	end
endmodule

// >>> tb/rx_ring_writeback_tb.sv
// bench: registers, chained and truncated frames, byte fetch
`timescale 1ns/1ns
module rx_ring_writeback_tb;
	logic        clock_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, slow;
	logic        s_axi_arvalid_i, s_axi_rready_i, rx_valid_i, rx_last_i, rx_crc_bad_i;
	logic        rx_bits_odd_i, tx_fetch_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_arready_o, s_axi_rvalid_o, tx_byte_valid_o, mem_req_o, mem_ack_i;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, rx_byte_i, tx_byte_o;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
	logic [17:0] tx_addr_i;
	logic [15:0] mem_rdata_i;
	int          fail_count = 0, num_checks = 0, cyc = 0;
	rx_ring_pkg::mem_cmd_s mem_cmd_o;
	// the host reports a bus timeout on every access in the 0x300 window
	rx_ring_writeback DUT (.clock_i, .nrst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i,
		.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
		.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .rx_valid_i, .rx_byte_i, .rx_last_i, .rx_crc_bad_i, .rx_bits_odd_i,
		.tx_fetch_i, .tx_addr_i, .tx_byte_o, .tx_byte_valid_o, .mem_req_o, .mem_cmd_o,
		.mem_rdata_i, .mem_ack_i, .mem_err_i(mem_ack_i && mem_cmd_o.addr[9:8] == 2'h3));
	host_mem_model MEM (.clock_i, .slow_i(slow), .req_i(mem_req_o), .cmd_i(mem_cmd_o),
		.rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// a hung run ends as a mismatch
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic mchk(input int i, input logic [15:0] e);
		chk({16'h0, MEM.mem[i]}, {16'h0, e});
	endtask
	// address and data are offered together; readies rise together
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do @(posedge clock_i); while (!(s_axi_awready_o && s_axi_wready_o));
		s_axi_awvalid_i <= 1'b0;
		s_axi_wvalid_i <= 1'b0;
		do @(posedge clock_i); while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
		r = s_axi_bresp_o;
		@(posedge clock_i);
	endtask
	task automatic axr(input logic [7:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge clock_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clock_i); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b0;
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
		@(posedge clock_i);
	endtask
	// entries are handed over between edges, away from the model's reads
	task automatic own(input int e, input logic [15:0] len, input logic [15:0] adr, input logic hi);
		@(negedge clock_i);
		MEM.mem[e*4] = len;
		MEM.mem[e*4+1] = adr;
		MEM.mem[e*4+2] = {15'h4000, hi};
		repeat (30) @(posedge clock_i);
	endtask
	// wide spacing keeps bytes clear of memory waits; a gap of 1 loses some
	task automatic frame(input int n, input logic crc, input logic odd, input int gap);
		for (int i = 0; i < n; i++)
		begin
			rx_byte_i <= 8'h10 + 8'(i);
			rx_valid_i <= 1'b1;
			rx_last_i <= (i == n - 1);
			rx_crc_bad_i <= crc;
			rx_bits_odd_i <= odd;
			@(posedge clock_i);
			rx_valid_i <= 1'b0;
			repeat (gap) @(posedge clock_i);
		end
		repeat (40) @(posedge clock_i);
	endtask
	initial
	begin
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i,
			rx_valid_i, rx_last_i, rx_crc_bad_i, rx_bits_odd_i, tx_fetch_i, s_axi_awaddr_i,
			s_axi_araddr_i, rx_byte_i, s_axi_wdata_i, tx_addr_i, nrst_i, slow} = '0;
		for (int i = 0; i < 2048; i++)
			MEM.mem[i] = 16'h0;
		MEM.mem[448] = 16'hbeef;
		repeat (16) @(posedge clock_i);
		nrst_i <= 1'b1;
		axr(8'h08);
		chk(d, 32'h1);
		axr(8'h40);
		chk({30'h0, r}, 32'h3);
		axw(8'h04, 32'h0);
		axw(8'h08, 32'h2);
		own(0, 16'h0004, 16'h0100, 1'b0);
		own(1, 16'h0040, 16'h0200, 1'b1);
		axw(8'h00, 32'h1);
		repeat (30) @(posedge clock_i);
		frame(6, 1'b0, 1'b0, 30);
		mchk(128, 16'h1110);
		mchk(129, 16'h1312);
		mchk(256, 16'h1514);
		mchk(2, 16'h0200);
		mchk(6, 16'h0101);
		mchk(7, 16'h0006);
		own(0, 16'h0002, 16'h0100, 1'b0);
		frame(3, 1'b1, 1'b1, 30);
		mchk(128, 16'h1110);
		mchk(2, 16'h6b00);
		mchk(3, 16'h8003);
		axw(8'h00, 32'h3);
		own(1, 16'h0002, 16'h0300, 1'b0);
		frame(4, 1'b0, 1'b0, 30);
		mchk(6, 16'h4300);
		mchk(7, 16'h6004);
		own(0, 16'h0008, 16'h0100, 1'b0);
		frame(3, 1'b0, 1'b0, 1);
		mchk(3, 16'h3003);
		mchk(2, 16'h4300);
		axw(8'h40, 32'h0);
		chk({30'h0, r}, 32'h3);
		slow <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			tx_addr_i <= 18'h381 - 18'(k);
			tx_fetch_i <= 1'b1;
			@(posedge clock_i);
			tx_fetch_i <= 1'b0;
			do @(posedge clock_i); while (!tx_byte_valid_o);
			chk({24'h0, tx_byte_o}, k ? 32'hef : 32'hbe);
		end
		axr(8'h0c);
		chk(d, 32'h00040201);
		end_sim();
	end
endmodule
